// [src/csw_defs.vh]
// Purpose: constants for the cpu status word block
// Assumes: 32-bit status word, bit positions fixed by the core
// Notes: included by csw_top.v
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSW_BIT_VF 23
`define CSW_CTX_HI 18
`define CSW_CTX_LO 16
`define CSW_BIT_OA 15
`define CSW_BIT_OB 14
`define CSW_BIT_SA 13
`define CSW_BIT_SB 12
`define CSW_BIT_OAB 11
`define CSW_BIT_SAB 10
`define CSW_BIT_TRAP_PRIORITY_TOP_BIT 8
`define CSW_IPL_HI 7
`define CSW_IPL_LO 5
`define CSW_BIT_RA 4
`define CSW_BIT_N 3
`define CSW_BIT_OV 2
`define CSW_BIT_Z 1
`define CSW_BIT_C 0
// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define CSW_RESET_WORD 32'h00000000
`define CSW_TRAP_LEVEL 4'h8
`define CSW_IPL_ALL_OFF 3'h7
`endif

// [src/csw_sticky.v]
// Purpose: one sticky status flag with software write
// Assumes: write and hardware set in same cycle, write wins
// Notes: set_i holds the flag; only a write can clear it
`timescale 1ns/1ps
module csw_sticky (
    core_clk,
    nrst,
    set_i,
    wr_en,
    wr_val,
    flag_q
);
    input core_clk;
    input nrst;
    input set_i;
    input wr_en;
    input wr_val;
    output flag_q;
    wire core_clk;
    wire nrst;
    wire set_i;
    wire wr_en;
    wire wr_val;
    reg flag_q;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (wr_en) begin
            flag_q <= wr_val; // R22
        end else if (set_i) begin
            flag_q <= 1'b1; // R7
        end
    end
endmodule // csw_sticky

// [src/csw_top.v]
// Purpose: cpu status word: context id, dsp sticky flags, priority, alu flags
// Assumes: single core clock, updates come from pipeline logic on same clock
// Notes: reached only through the status-word operand path, no memory map
// Notes on behaviour
// R1 - three-bit active context id, contexts zero-seven
// R2 - context id ignores instruction writes
// R3 - set accumulator frac overflow beyond 1.31
// R4 - set clip sticky on saturate or bit71
// R5 - bit 11 is OR of overflows
// R6 - bit 10 is OR of clip stickies
// R7 - dsp overflow/clip flags stay set until written
// R8 - clearing combined bit clears both members
// R9 - priority top bit high when priority eight+
// R10 - priority field masks interrupt levels
// R11 - reset priority zero, supervisor; user read-only
// R12 - repeat-active mirrors loop, not writable
// R13 - zero flag sticky, cleared by nonzero result
// R14 - alu n ov z c in bits three-zero
// R15 - vector-fetch-fail read-only, hardware owned
// R16 - full word pushed on exception entry
// R17 - no memory map, status operand only
// R18 - context id follows every context change outside a trap
// R19 - traps keep the current context id
// R20 - vector fail selects fail address data
// R21 - read-only and unused bits ignore writes
// R22 - instruction write beats hardware update
`timescale 1ns/1ps
`include "csw_defs.vh"
module csw_top #(
    parameter VEC_W = 24
) (
    core_clk,
    nrst,
    sw_wr_en,
    sw_wr_data,
    sw_rd_en,
    sw_rd_data,
    user_mode,
    ctx_change,
    ctx_new,
    trap_entry,
    exc_entry,
    exc_push_word,
    exc_return,
    exc_restore_word,
    prio_set,
    prio_new,
    acc_a_frac_ovf_evt,
    acc_b_frac_ovf_evt,
    acc_a_sat_evt,
    acc_b_sat_evt,
    acc_a_bit71_evt,
    acc_b_bit71_evt,
    sat_enable_a,
    sat_enable_b,
    repeat_active,
    vf_set,
    vf_clear,
    vec_fetch_data,
    vec_fail_addr,
    vec_data_out,
    alu_upd,
    alu_n,
    alu_ov,
    alu_zero_result,
    alu_c,
    cpu_status_word,
    irq_level_enable,
    trap_priority_top_bit
);
    input core_clk;
    input nrst;
    input sw_wr_en;
    input [31:0] sw_wr_data;
    input sw_rd_en;
    output [31:0] sw_rd_data;
    input user_mode;
    input ctx_change;
    input [2:0] ctx_new;
    input trap_entry;
    input exc_entry;
    output [31:0] exc_push_word;
    input exc_return;
    input [31:0] exc_restore_word;
    input prio_set;
    input [3:0] prio_new;
    input acc_a_frac_ovf_evt;
    input acc_b_frac_ovf_evt;
    input acc_a_sat_evt;
    input acc_b_sat_evt;
    input acc_a_bit71_evt;
    input acc_b_bit71_evt;
    input sat_enable_a;
    input sat_enable_b;
    input repeat_active;
    input vf_set;
    input vf_clear;
    input [VEC_W-1:0] vec_fetch_data;
    input [VEC_W-1:0] vec_fail_addr;
    output [VEC_W-1:0] vec_data_out;
    input [3:0] alu_upd;
    input alu_n;
    input alu_ov;
    input alu_zero_result;
    input alu_c;
    output [31:0] cpu_status_word;
    output [7:1] irq_level_enable;
    output trap_priority_top_bit;

    wire core_clk;
    wire nrst;
    wire sw_wr_en;
    wire [31:0] sw_wr_data;
    wire sw_rd_en;
    wire user_mode;
    wire ctx_change;
    wire [2:0] ctx_new;
    wire trap_entry;
    wire exc_entry;
    wire exc_return;
    wire [31:0] exc_restore_word;
    wire prio_set;
    wire [3:0] prio_new;
    wire acc_a_frac_ovf_evt;
    wire acc_b_frac_ovf_evt;
    wire acc_a_sat_evt;
    wire acc_b_sat_evt;
    wire acc_a_bit71_evt;
    wire acc_b_bit71_evt;
    wire sat_enable_a;
    wire sat_enable_b;
    wire repeat_active;
    wire vf_set;
    wire vf_clear;
    wire [VEC_W-1:0] vec_fetch_data;
    wire [VEC_W-1:0] vec_fail_addr;
    wire [3:0] alu_upd;
    wire alu_n;
    wire alu_ov;
    wire alu_zero_result;
    wire alu_c;
    reg [31:0] sw_rd_data;
    reg [31:0] exc_push_word;
    reg [VEC_W-1:0] vec_data_out;
    reg [31:0] cpu_status_word;
    reg [7:1] irq_level_enable;
    reg trap_priority_top_bit;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [2:0] active_context_id_r;
    reg [2:0] active_context_id_nxt;
    reg [3:0] cpu_priority_level_r;
    reg [3:0] cpu_priority_level_nxt;
    reg loop_running_flag_r;
    reg vector_fetch_fail_r;
    reg vector_fetch_fail_nxt;
    reg alu_n_r;
    reg alu_ov_r;
    reg alu_z_r;
    reg alu_c_r;
    reg [3:0] alu_nxt;
    wire accum_a_frac_ovf;
    wire accum_b_frac_ovf;
    wire accum_a_clip_sticky;
    wire accum_b_clip_sticky;
    wire either_accum_frac_ovf;
    wire either_accum_clip_sticky;
    reg [31:0] word_now;
    reg [7:1] lvl_en_nxt;
    integer i;

    // a return restores the stacked word as if written, so flags come back
    wire wr_any = sw_wr_en | exc_return;
    wire [31:0] wr_word = exc_return ? exc_restore_word : sw_wr_data;

    // clearing a combined bit clears both members; a member write is
    // otherwise the plain per-bit write
    wire oab_clr = wr_any & ~wr_word[`CSW_BIT_OAB]; // R8
    wire sab_clr = wr_any & ~wr_word[`CSW_BIT_SAB]; // R8
    wire oa_we = wr_any;
    wire oa_wv = wr_word[`CSW_BIT_OA] & ~oab_clr;
    wire ob_wv = wr_word[`CSW_BIT_OB] & ~oab_clr;
    wire sa_wv = wr_word[`CSW_BIT_SA] & ~sab_clr;
    wire sb_wv = wr_word[`CSW_BIT_SB] & ~sab_clr;

    // without saturation a spill into bit 71 counts as the clip event
    wire sa_evt = sat_enable_a ? acc_a_sat_evt : acc_a_bit71_evt; // R4
    wire sb_evt = sat_enable_b ? acc_b_sat_evt : acc_b_bit71_evt; // R4

    // ----------------------------------------------------------------
    // sticky dsp flags
    // ----------------------------------------------------------------
    csw_sticky u_oa (
        .core_clk(core_clk),
        .nrst(nrst),
        .set_i(acc_a_frac_ovf_evt), // R3
        .wr_en(oa_we),
        .wr_val(oa_wv),
        .flag_q(accum_a_frac_ovf)
    );
    csw_sticky u_ob (
        .core_clk(core_clk),
        .nrst(nrst),
        .set_i(acc_b_frac_ovf_evt), // R3
        .wr_en(oa_we),
        .wr_val(ob_wv),
        .flag_q(accum_b_frac_ovf)
    );
    csw_sticky u_sa (
        .core_clk(core_clk),
        .nrst(nrst),
        .set_i(sa_evt),
        .wr_en(oa_we),
        .wr_val(sa_wv),
        .flag_q(accum_a_clip_sticky)
    );
    csw_sticky u_sb (
        .core_clk(core_clk),
        .nrst(nrst),
        .set_i(sb_evt),
        .wr_en(oa_we),
        .wr_val(sb_wv),
        .flag_q(accum_b_clip_sticky)
    );
    assign either_accum_frac_ovf = accum_a_frac_ovf | accum_b_frac_ovf; // R5
    assign either_accum_clip_sticky = accum_a_clip_sticky | accum_b_clip_sticky; // R6

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always @* begin
        active_context_id_nxt = active_context_id_r;
        if (ctx_change && !trap_entry) begin
            active_context_id_nxt = ctx_new; // R18 R19
        end else if (exc_return) begin
            active_context_id_nxt = exc_restore_word[`CSW_CTX_HI:`CSW_CTX_LO];
        end
        // R2: sw_wr_data never reaches the context id

        cpu_priority_level_nxt = cpu_priority_level_r;
        if (prio_set) begin
            cpu_priority_level_nxt = prio_new;
        end
        if (exc_return) begin
            cpu_priority_level_nxt = {exc_restore_word[`CSW_BIT_TRAP_PRIORITY_TOP_BIT],
                                      exc_restore_word[`CSW_IPL_HI:`CSW_IPL_LO]};
        end else if (sw_wr_en && !user_mode) begin
            // top bit tracks hardware only; software sets the low field
            cpu_priority_level_nxt = {cpu_priority_level_nxt[3],
                                      sw_wr_data[`CSW_IPL_HI:`CSW_IPL_LO]}; // R11 R22
        end

        vector_fetch_fail_nxt = vector_fetch_fail_r;
        if (vf_set) begin
            vector_fetch_fail_nxt = 1'b1; // R15
        end else if (vf_clear) begin
            vector_fetch_fail_nxt = 1'b0; // R15
        end

        alu_nxt = {alu_n_r, alu_ov_r, alu_z_r, alu_c_r};
        if (alu_upd[3]) begin
            alu_nxt[3] = alu_n;
        end
        if (alu_upd[2]) begin
            alu_nxt[2] = alu_ov;
        end
        if (alu_upd[1]) begin
            alu_nxt[1] = alu_z_r & alu_zero_result; // R13
        end
        if (alu_upd[0]) begin
            alu_nxt[0] = alu_c;
        end
        if (wr_any) begin
            alu_nxt = wr_word[`CSW_BIT_N:`CSW_BIT_C]; // R14 R22
        end

        word_now = 32'h00000000; // R21
        word_now[`CSW_BIT_VF] = vector_fetch_fail_r;
        word_now[`CSW_CTX_HI:`CSW_CTX_LO] = active_context_id_r; // R1
        word_now[`CSW_BIT_OA] = accum_a_frac_ovf;
        word_now[`CSW_BIT_OB] = accum_b_frac_ovf;
        word_now[`CSW_BIT_SA] = accum_a_clip_sticky;
        word_now[`CSW_BIT_SB] = accum_b_clip_sticky;
        word_now[`CSW_BIT_OAB] = either_accum_frac_ovf;
        word_now[`CSW_BIT_SAB] = either_accum_clip_sticky;
        word_now[`CSW_BIT_TRAP_PRIORITY_TOP_BIT] = cpu_priority_level_r[3];
        word_now[`CSW_IPL_HI:`CSW_IPL_LO] = cpu_priority_level_r[2:0];
        word_now[`CSW_BIT_RA] = loop_running_flag_r;
        word_now[`CSW_BIT_N:`CSW_BIT_C] = {alu_n_r, alu_ov_r, alu_z_r, alu_c_r};

        // code k enables levels above k; 111 enables none
        lvl_en_nxt = 7'h00;
        for (i = 1; i <= 7; i = i + 1) begin
            lvl_en_nxt[i] = (cpu_priority_level_nxt[3] == 1'b0) &&
                            (i > cpu_priority_level_nxt[2:0]); // R10
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            active_context_id_r <= 3'h0;
            cpu_priority_level_r <= 4'h0; // R11
            loop_running_flag_r <= 1'b0;
            vector_fetch_fail_r <= 1'b0;
            alu_n_r <= 1'b0;
            alu_ov_r <= 1'b0;
            alu_z_r <= 1'b0;
            alu_c_r <= 1'b0;
            sw_rd_data <= `CSW_RESET_WORD;
            exc_push_word <= `CSW_RESET_WORD;
            vec_data_out <= {VEC_W{1'b0}};
            cpu_status_word <= `CSW_RESET_WORD;
            irq_level_enable <= 7'h7F;
            trap_priority_top_bit <= 1'b0;
        end else begin
            active_context_id_r <= active_context_id_nxt;
            cpu_priority_level_r <= cpu_priority_level_nxt;
            loop_running_flag_r <= repeat_active; // R12
            vector_fetch_fail_r <= vector_fetch_fail_nxt;
            alu_n_r <= alu_nxt[3];
            alu_ov_r <= alu_nxt[2];
            alu_z_r <= alu_nxt[1];
            alu_c_r <= alu_nxt[0];
            if (sw_rd_en) begin
                sw_rd_data <= word_now; // R17
            end
            if (exc_entry) begin
                exc_push_word <= word_now; // R16
            end
            vec_data_out <= vector_fetch_fail_nxt ? vec_fail_addr : vec_fetch_data; // R20
            cpu_status_word <= word_now;
            irq_level_enable <= lvl_en_nxt;
            trap_priority_top_bit <= (cpu_priority_level_nxt >= `CSW_TRAP_LEVEL); // R9
        end
    end
endmodule // csw_top

// [dv/csw_chk_assertions.sv]
// Purpose: port checker for the status word block
// Assumes: word output lags register state by one edge
// Notes: bound into csw_top
`timescale 1ns/1ps
module csw_chk #(
    parameter VEC_W = 24
) (
    input logic core_clk,
    input logic nrst,
    input logic sw_wr_en,
    input logic sw_rd_en,
    input logic [31:0] sw_rd_data,
    input logic ctx_change,
    input logic trap_entry,
    input logic exc_entry,
    input logic [31:0] exc_push_word,
    input logic exc_return,
    input logic [3:0] alu_upd,
    input logic alu_zero_result,
    input logic repeat_active,
    input logic vf_set,
    input logic [VEC_W-1:0] vec_fail_addr,
    input logic [VEC_W-1:0] vec_data_out,
    input logic [31:0] cpu_status_word,
    input logic [7:1] irq_level_enable,
    input logic trap_priority_top_bit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_vf_seen;
        vec_data_out == $past(vec_fail_addr) ##1 cpu_status_word[23];
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_unused_zero: assert property ((cpu_status_word & 32'hFF780200) == 32'h0)
        else $error("unused bit set");
    chk_oab_or: assert property (cpu_status_word[11] == |cpu_status_word[15:14])
        else $error("combined overflow wrong");
    chk_sab_or: assert property (cpu_status_word[10] == |cpu_status_word[13:12])
        else $error("combined clip wrong");
    chk_top_bit: assert property (cpu_status_word[8] == $past(trap_priority_top_bit))
        else $error("top bit disagrees");
    chk_trap_mask: assert property
        (trap_priority_top_bit |-> irq_level_enable == 7'h00)
        else $error("irq enabled in trap");
    chk_sticky_hold: assert property
        (($fell(cpu_status_word[15]) || $fell(cpu_status_word[13]) ||
        $fell(cpu_status_word[14]) || $fell(cpu_status_word[12]))
        |-> ($past(sw_wr_en, 2) || $past(exc_return, 2)))
        else $error("sticky flag dropped");
    chk_ctx_source: assert property ($changed(cpu_status_word[18:16]) |->
        ($past(ctx_change, 2) && !$past(trap_entry, 2)) || $past(exc_return, 2))
        else $error("context id moved");
    chk_loop_flag: assert property (cpu_status_word[4] == $past(repeat_active, 2))
        else $error("loop flag wrong");
    chk_vf_fetch: assert property (vf_set |=> s_vf_seen)
        else $error("vector fail path wrong");
    chk_zero_clear: assert property
        ((alu_upd[1] && !alu_zero_result && !sw_wr_en && !exc_return)
        |-> ##2 !cpu_status_word[1])
        else $error("zero flag kept");
    chk_push_word: assert property ((exc_entry && sw_rd_en) |=> exc_push_word == sw_rd_data)
        else $error("pushed word wrong");
    chk_reset_clear: assert property ($rose(nrst) |-> cpu_status_word == 32'h0
        && irq_level_enable == 7'h7F && !trap_priority_top_bit)
        else $error("reset state wrong");
endmodule // csw_chk
bind csw_top csw_chk #(.VEC_W(VEC_W)) i_csw_chk (.*);

// [dv/csw_pipe.sv]
// Purpose: pipeline side that feeds hardware updates
// Assumes: caller changes values just after a rising edge
// Notes: vector lines carry fresh junk each drive, never stale data
`timescale 1ns/1ps
module csw_pipe (
    output logic [31:0] hw,
    output logic [23:0] vec_fetch_data,
    output logic [23:0] vec_fail_addr
);
    initial begin
        hw = 32'h0;
        vec_fetch_data = 24'h0;
        vec_fail_addr = 24'h0;
    end
    task automatic drive(input logic [31:0] v, input logic [63:0] r);
        hw = v;
        vec_fetch_data = r[23:0];
        vec_fail_addr = r[55:32];
    endtask
endmodule // csw_pipe

// [dv/tb.sv]
// Purpose: self-checking bench for the status word block
// Assumes: reads capture the word as it stood before the edge
// Notes: expected words kept in m, compared by the read monitor
`timescale 1ns/1ps
module tb;
    logic core_clk, nrst, sw_wr_en, sw_rd_en, user_mode, trap_entry, sat_enable_a;
    logic sat_enable_b, repeat_active, ctx_change, exc_entry, exc_return, prio_set;
    logic acc_a_frac_ovf_evt, acc_b_frac_ovf_evt, acc_a_sat_evt, acc_b_sat_evt;
    logic acc_a_bit71_evt, acc_b_bit71_evt, vf_set, vf_clear, alu_n, alu_ov;
    logic alu_zero_result, alu_c, trap_priority_top_bit, pe;
    logic [2:0] ctx_new;
    logic [3:0] alu_upd, prio_new;
    logic [7:1] irq_level_enable;
    logic [23:0] vec_fetch_data, vec_fail_addr, vec_data_out;
    logic [31:0] sw_wr_data, sw_rd_data, exc_restore_word, exc_push_word, cpu_status_word;
    logic [31:0] hw, lv, m, d, nt;
    logic [71:0] got, want;
    logic [31:0] q[$];
    integer seed, miscompares, comparisons, i;
    assign {user_mode, trap_entry, sat_enable_a, sat_enable_b, repeat_active, ctx_change,
        exc_entry, exc_return, prio_set, acc_a_frac_ovf_evt, acc_b_frac_ovf_evt, acc_a_sat_evt,
        acc_b_sat_evt, acc_a_bit71_evt, acc_b_bit71_evt, vf_set, vf_clear, alu_n, alu_ov,
        alu_zero_result, alu_c, alu_upd, prio_new, ctx_new} = hw;
    csw_pipe i_pipe (.hw, .vec_fetch_data, .vec_fail_addr);
    csw_top i_csw_top (.*);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] wr(input logic [31:0] o, input logic [31:0] v, input logic u);
        logic [31:0] n;
        n = o;
        n[3:0] = v[3:0];
        if (!u) begin
            n[7:5] = v[7:5];
        end
        n[15:12] = v[15:12] & {v[11], v[11], v[10], v[10]};
        n[11] = n[15] | n[14];
        n[10] = n[13] | n[12];
        return n;
    endfunction
    function automatic logic [7:0] ex(input logic [31:0] w);
        logic [7:0] e;
        for (int k = 1; k < 8; k++) begin
            e[k] = !w[8] && (k > w[7:5]);
        end
        e[0] = w[8];
        return e;
    endfunction
    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic step(input logic we, input logic [31:0] wd, input logic [31:0] h);
        sw_wr_en = we;
        sw_wr_data = wd;
        i_pipe.drive(h | lv, {$random(seed), $random(seed)});
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] x);
        step(1'b0, 32'h0, 32'h0);
        q.push_back(e);
        sw_rd_en = 1'b1;
        step(1'b0, 32'h0, x);
        sw_rd_en = 1'b0;
    endtask
    task automatic conclude;
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (sw_rd_en === 1'b1) begin
            // sample the push strobe at the edge; the driver moves it 1 ns later
            pe = exc_entry;
            #2;
            nt = q.pop_front();
            want = {nt, nt, ex(nt)};
            got = {sw_rd_data, cpu_status_word, irq_level_enable, trap_priority_top_bit};
            comparisons = comparisons + 1;
            if (got !== want) begin
                $display("wrong value at %0t: got %h exp %h", $time, got, want);
                miscompares = miscompares + 1;
            end
            if (pe === 1'b1) begin
                comparisons = comparisons + 1;
                if (exc_push_word !== nt) begin
                    $display("wrong value at %0t: got %h exp %h", $time, exc_push_word, nt);
                    miscompares = miscompares + 1;
                end
            end
        end
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        miscompares = miscompares + 1;
        conclude();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h8EA9;
        miscompares = 0;
        comparisons = 0;
        lv = 32'h0;
        m = 32'h0;
        nrst = 1'b0;
        sw_wr_en = 1'b0;
        sw_rd_en = 1'b0;
        sw_wr_data = 32'h0;
        exc_restore_word = 32'h0;
        repeat (2) @(posedge core_clk);
        #1 nrst = 1'b1;
        chk(m, 32'h0);
        for (i = 0; i < 8; i++) begin
            d = $random(seed) | 32'h100;
            lv = i[0] ? 32'h8000_0000 : 32'h0;
            step(1'b1, d, 32'h0);
            m = wr(m, d, lv[31]);
            chk(m, 32'h0);
        end
        lv = 32'h3000_0000;
        step(1'b0, 32'h0, 32'h0040_0000);
        step(1'b0, 32'h0, 32'h0004_0000);
        step(1'b0, 32'h0, 32'h0008_0000);
        m = m | 32'h9C00;
        chk(m, 32'h0);
        lv = 32'h0;
        step(1'b0, 32'h0, 32'h0010_0000);
        step(1'b0, 32'h0, 32'h0004_0000);
        step(1'b0, 32'h0, 32'h0020_0000);
        m = m | 32'h6000;
        chk(m, 32'h0);
        lv = 32'h3000_0000;
        step(1'b1, 32'h0000_A500, 32'h0048_0000);
        m = wr(m, 32'h0000_A500, 1'b0);
        chk(m, 32'h0);
        lv = 32'h0;
        step(1'b1, 32'h0000_0102, 32'h0);
        m = wr(m, 32'h0000_0102, 1'b0);
        step(1'b0, 32'h0, 32'h0000_7F80);
        m[3:0] = 4'hF;
        chk(m, 32'h0);
        step(1'b0, 32'h0, 32'h0000_0100);
        step(1'b0, 32'h0, 32'h0000_1100);
        m[1] = 1'b0;
        chk(m, 32'h0);
        step(1'b0, 32'h0, 32'h0080_0048);
        step(1'b0, 32'h0, 32'h4400_0005);
        lv = 32'h0800_0000;
        step(1'b0, 32'h0, 32'h0400_0006);
        step(1'b0, 32'h0, 32'h0001_8000);
        m[8:5] = 4'h9;
        m[18:16] = 3'h6;
        m[4] = 1'b1;
        m[23] = 1'b1;
        chk(m, 32'h0);
        step(1'b1, 32'hFFFF_FFFF, 32'h0);
        m = wr(m, 32'hFFFF_FFFF, 1'b0);
        chk(m, 32'h0200_0000);
        d = $random(seed) & 32'h0007_F1EF;
        d[11] = d[15] | d[14];
        d[10] = d[13] | d[12];
        exc_restore_word = d;
        step(1'b1, ~d, 32'h0100_8000);
        m = d | (m & 32'h0000_0010);
        chk(m, 32'h0);
        // one more edge so the last read is compared before the verdict
        step(1'b0, 32'h0, 32'h0);
        conclude();
    end
endmodule // tb
